// ### common/enc_link_pkg.sv
/*
  Shared constants, types and the frame checksum step for the serial
  position link, used by the encoder end and the master end.
  Assumes a 125 MHz system clock on both ends.
*/
package enc_link_pkg;
  // ==========================================================
  // frame layout
  localparam int POS_W    = 20;
  localparam int RES_MIN  = 17;
  localparam int CRC_W    = 6;
  localparam int TRAIL_W  = 11;
  localparam logic [5:0] CRC_POLY = 6'h03;
  localparam logic [5:0] CRC_INIT = 6'h00;
  typedef logic [1:0] res_sel_t;
  // ==========================================================
  // timing
  localparam int CLK_NS     = 8;
  localparam int SYS_KHZ    = 125000;
  localparam int TMO_NS     = 25000;
  localparam int TMO_CYCLES = (TMO_NS + CLK_NS - 1) / CLK_NS;
  localparam int TMR_W      = 12;
  localparam int FMAX_KHZ   = 5000;
  localparam int FMIN_KHZ   = 100;
  localparam int HALF_MIN   = (SYS_KHZ + 2 * FMAX_KHZ - 1) / (2 * FMAX_KHZ);
  localparam int HALF_MAX   = SYS_KHZ / (2 * FMIN_KHZ);
  localparam int DIV_W      = 10;
  localparam logic [9:0] DIV_RST = 10'h032;
  // ==========================================================
  // master registers, byte addresses
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_DIV  = 5'h04;
  localparam logic [4:0] REG_STAT = 5'h08;
  localparam logic [4:0] REG_MASK = 5'h0C;
  localparam logic [4:0] REG_POS  = 5'h10;
  localparam int CTRL_START = 0;
  localparam int CTRL_RES   = 1;
  localparam int STAT_BUSY  = 0;
  localparam int EV_LO      = 1;
  localparam int EV_W       = 4;
  localparam int EV_DONE    = 0;
  localparam int EV_CRC     = 1;
  localparam int EV_FRAME   = 2;
  localparam int EV_FAULT   = 3;
  // ==========================================================
  // states
  typedef enum {D_IDLE, D_ACK, D_START, D_ZERO, D_POS, D_ERR, D_WARN, D_CRC, D_TMO} dev_state_t;
  typedef enum {M_IDLE, M_LOW, M_HIGH, M_GAP} mst_state_t;

  function automatic logic [5:0] crc_step(input logic [5:0] crc, input logic din);
    logic fb;
    fb = crc[5] ^ din;
    crc_step = {crc[4:0], 1'b0} ^ (fb ? CRC_POLY : CRC_INIT);
  endfunction : crc_step
endpackage : enc_link_pkg

// ### common/enc_link_if.sv
/*
  The two wires between master and encoder, single ended here.
  Assumes the bench joins the two ends through one instance.
*/
`timescale 1ns/1ps
`default_nettype none
interface enc_link_if;
  logic linkClk;  // master clock, also service receive line
  logic linkData; // encoder data, also service transmit line
  modport master  (output linkClk, input linkData);
  modport encoder (input linkClk, output linkData);
endinterface : enc_link_if
`default_nettype wire

// ### hdl/enc_slave_end.sv
/*
  Encoder end of the serial position link: answers each master clock
  burst with one position frame, or passes the service line through.
  Assumes the master clock is asynchronous and slow against clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module enc_slave_end #(
  parameter bit hasBit = 1'b1                    // self-test option fitted
) (
  input  wire logic                       clk_sys,   // system clock
  input  wire logic                       rstn,      // async reset, low
  enc_link_if.encoder                     link,      // serial link
  input  wire logic [enc_link_pkg::POS_W-1:0] position, // absolute position
  input  wire enc_link_pkg::res_sel_t     resSel,    // 0..3 = 17..20 bits
  input  wire logic                       bitOk,     // internal signals fine
  input  wire logic                       svcReq,    // ask for service mode
  input  wire logic                       svcTx,     // service transmit bit
  output logic                            svcRx,     // service receive bit
  output logic                            svcActive, // in service mode
  output logic                            frameActive // frame or pause running
);
  import enc_link_pkg::*;

  // ==========================================================
  // clock line synchroniser and edge finder
  logic [1:0] clkSync_reg;
  logic [1:0] clkSync_next;
  logic       clkSeen_reg;
  logic       clkSeen_next;
  logic       riseTick;

  always_comb begin
    clkSync_next = {clkSync_reg[0], link.linkClk};
    clkSeen_next = clkSync_reg[1];
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      clkSync_reg <= 2'h3;
      clkSeen_reg <= 1'b1;
    end else begin
      clkSync_reg <= clkSync_next;
      clkSeen_reg <= clkSeen_next;
    end
  end

  assign riseTick = clkSync_reg[1] & ~clkSeen_reg;

  // ==========================================================
  // frame sequencer
  dev_state_t         state_reg;
  dev_state_t         state_next;
  logic               data_reg;
  logic               data_next;
  logic [POS_W-1:0]   posSh_reg;
  logic [POS_W-1:0]   posSh_next;
  logic [CRC_W-1:0]   crc_reg;
  logic [CRC_W-1:0]   crc_next;
  logic [4:0]         cnt_reg;
  logic [4:0]         cnt_next;
  logic [4:0]         resLen_reg;
  logic [4:0]         resLen_next;
  logic               err_reg;
  logic               err_next;
  logic [TMR_W-1:0]   tmr_reg;
  logic [TMR_W-1:0]   tmr_next;
  logic               svc_reg;
  logic               svc_next;
  logic               rx_reg;
  logic               rx_next;
  logic [4:0]         resNow;

  assign resNow = 5'(RES_MIN) + {3'h0, resSel};

  always_comb begin
    state_next  = state_reg;
    data_next   = data_reg;
    posSh_next  = posSh_reg;
    crc_next    = crc_reg;
    cnt_next    = cnt_reg;
    resLen_next = resLen_reg;
    err_next    = err_reg;
    tmr_next    = tmr_reg;
    svc_next    = svc_reg;
    rx_next     = clkSync_reg[1];
    case (state_reg)
      D_IDLE: begin
        // mode only changes between frames, so no frame is torn
        svc_next = svcReq;
        if (svc_reg) begin
          data_next = svcTx;
        end else if (riseTick) begin
          data_next   = 1'b0;
          resLen_next = resNow;
          posSh_next  = position << (5'(POS_W) - resNow);
          err_next    = hasBit ? bitOk : 1'b1;
          crc_next    = CRC_INIT;
          state_next  = D_ACK;
        end else begin
          data_next = 1'b1;
        end
      end
      D_ACK: begin
        if (riseTick) begin
          data_next  = 1'b1;
          state_next = D_START;
        end
      end
      D_START: begin
        if (riseTick) begin
          data_next  = 1'b0;
          state_next = D_ZERO;
        end
      end
      D_ZERO: begin
        if (riseTick) begin
          // checksum starts with the first position bit
          data_next  = posSh_reg[POS_W-1];
          crc_next   = crc_step(crc_reg, posSh_reg[POS_W-1]);
          posSh_next = {posSh_reg[POS_W-2:0], 1'b0};
          cnt_next   = 5'h01;
          state_next = D_POS;
        end
      end
      D_POS: begin
        if (riseTick) begin
          if (cnt_reg == resLen_reg) begin
            data_next  = err_reg;
            crc_next   = crc_step(crc_reg, err_reg);
            state_next = D_ERR;
          end else begin
            data_next  = posSh_reg[POS_W-1];
            crc_next   = crc_step(crc_reg, posSh_reg[POS_W-1]);
            posSh_next = {posSh_reg[POS_W-2:0], 1'b0};
            cnt_next   = cnt_reg + 5'h01;
          end
        end
      end
      D_ERR: begin
        if (riseTick) begin
          data_next  = 1'b1;
          crc_next   = crc_step(crc_reg, 1'b1);
          state_next = D_WARN;
        end
      end
      D_WARN: begin
        if (riseTick) begin
          data_next  = ~crc_reg[CRC_W-1];
          crc_next   = {crc_reg[CRC_W-2:0], 1'b0};
          cnt_next   = 5'h01;
          state_next = D_CRC;
        end
      end
      D_CRC: begin
        if (riseTick) begin
          data_next = ~crc_reg[CRC_W-1];
          crc_next  = {crc_reg[CRC_W-2:0], 1'b0};
          cnt_next  = cnt_reg + 5'h01;
          if (cnt_reg == 5'(CRC_W - 1)) begin
            // pause starts with the last bit: no extra rise is needed,
            // and the bit stays on the line for its late sample
            tmr_next   = '0;
            state_next = D_TMO;
          end
        end
      end
      D_TMO: begin
        if (tmr_reg == TMR_W'(TMO_CYCLES - 1)) begin
          data_next  = 1'b1;
          state_next = D_IDLE;
        end else begin
          tmr_next = tmr_reg + 12'h001;
        end
      end
      default: begin
        state_next = D_IDLE;
        data_next  = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_reg  <= D_IDLE;
      data_reg   <= 1'b1;
      posSh_reg  <= '0;
      crc_reg    <= CRC_INIT;
      cnt_reg    <= '0;
      resLen_reg <= 5'(RES_MIN);
      err_reg    <= 1'b1;
      tmr_reg    <= '0;
      svc_reg    <= 1'b0;
      rx_reg     <= 1'b1;
    end else begin
      state_reg  <= state_next;
      data_reg   <= data_next;
      posSh_reg  <= posSh_next;
      crc_reg    <= crc_next;
      cnt_reg    <= cnt_next;
      resLen_reg <= resLen_next;
      err_reg    <= err_next;
      tmr_reg    <= tmr_next;
      svc_reg    <= svc_next;
      rx_reg     <= rx_next;
    end
  end

  assign link.linkData = data_reg;
  assign svcRx         = rx_reg;
  assign svcActive     = svc_reg;
  assign frameActive   = (state_reg != D_IDLE);
endmodule : enc_slave_end
`default_nettype wire

// ### hdl/enc_master_end.sv
/*
  Master end of the serial position link with an Avalon-MM slave for
  software: starts frames, clocks them in, checks them, raises irq.
  Assumes the encoder answers as the encoder end does.
*/
// Added by the designer: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module enc_master_end (
  input  wire logic        clk_sys,     // system clock
  input  wire logic        rstn,        // async reset, low
  input  wire logic [4:0]  address,     // byte address
  input  wire logic        read,        // read request
  input  wire logic        write,       // write request
  input  wire logic [31:0] writedata,   // write data
  input  wire logic [3:0]  byteenable,  // byte lanes
  output logic [31:0]      readdata,    // read data
  output logic             waitrequest, // stall
  output logic             irq,         // level interrupt
  enc_link_if.master       link         // serial link
);
  import enc_link_pkg::*;

  // ==========================================================
  // register bus, one wait state per access
  logic             ack_reg;
  logic             ack_next;
  logic [31:0]      rd_reg;
  logic [31:0]      rd_next;
  logic [1:0]       res_reg;
  logic [1:0]       res_next;
  logic [DIV_W-1:0] div_reg;
  logic [DIV_W-1:0] div_next;
  logic [EV_W-1:0]  stat_reg;
  logic [EV_W-1:0]  stat_next;
  logic [EV_W-1:0]  mask_reg;
  logic [EV_W-1:0]  mask_next;
  logic [POS_W-1:0] pos_reg;
  logic             irq_reg;
  logic             irq_next;
  logic [31:0]      beMask;
  logic [31:0]      wd;
  logic             wrDo;
  logic             startReq;
  logic [EV_W-1:0]  evSet;
  logic             busy;

  assign beMask   = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
  assign wd       = writedata & beMask;
  assign wrDo     = write & ack_reg;
  assign startReq = wrDo & (address == REG_CTRL) & wd[CTRL_START];
  assign waitrequest = (read | write) & ~ack_reg;

  always_comb begin
    ack_next  = (read | write) & ~ack_reg;
    rd_next   = rd_reg;
    res_next  = res_reg;
    div_next  = div_reg;
    mask_next = mask_reg;
    // a new event beats a clear in the same cycle
    stat_next = stat_reg | evSet;
    if (read & ~ack_reg) begin
      case (address)
        REG_CTRL: rd_next = {29'h0, res_reg, 1'b0};
        REG_DIV:  rd_next = {22'h0, div_reg};
        REG_STAT: rd_next = {27'h0, stat_reg, busy};
        REG_MASK: rd_next = {27'h0, mask_reg, 1'b0};
        REG_POS:  rd_next = {12'h0, pos_reg};
        default:  rd_next = 32'h0000_0000;
      endcase
    end
    if (wrDo) begin
      case (address)
        REG_CTRL: if (byteenable[0]) res_next = wd[CTRL_RES +: 2];
        REG_DIV: begin
          if (byteenable[1:0] == 2'h3) begin
            // clamp keeps the link clock inside its legal band
            if (wd[15:0] < 16'(HALF_MIN))      div_next = DIV_W'(HALF_MIN);
            else if (wd[15:0] > 16'(HALF_MAX)) div_next = DIV_W'(HALF_MAX);
            else                               div_next = wd[DIV_W-1:0];
          end
        end
        REG_STAT: stat_next = (stat_reg & ~wd[EV_LO +: EV_W]) | evSet;
        REG_MASK: if (byteenable[0]) mask_next = wd[EV_LO +: EV_W];
        default: ;
      endcase
    end
    irq_next = |(stat_next & mask_next);
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ack_reg  <= 1'b0;
      rd_reg   <= '0;
      res_reg  <= '0;
      div_reg  <= DIV_RST;
      stat_reg <= '0;
      mask_reg <= '0;
      irq_reg  <= 1'b0;
    end else begin
      ack_reg  <= ack_next;
      rd_reg   <= rd_next;
      res_reg  <= res_next;
      div_reg  <= div_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      irq_reg  <= irq_next;
    end
  end

  assign readdata = rd_reg;
  assign irq      = irq_reg;

  // ==========================================================
  // link sequencer
  logic [1:0]       dSync_reg;
  mst_state_t       st_reg;
  mst_state_t       st_next;
  logic             clk_reg;
  logic             clk_next;
  logic [DIV_W-1:0] dc_reg;
  logic [DIV_W-1:0] dc_next;
  logic [4:0]       idx_reg;
  logic [4:0]       idx_next;
  logic [4:0]       len_reg;
  logic [4:0]       len_next;
  logic [POS_W-1:0] psh_reg;
  logic [POS_W-1:0] psh_next;
  logic [POS_W-1:0] pos_next;
  logic [CRC_W-1:0] crc_reg;
  logic [CRC_W-1:0] crc_next;
  logic [CRC_W-1:0] rxc_reg;
  logic [CRC_W-1:0] rxc_next;
  logic             bad_reg;
  logic             bad_next;
  logic             err_reg;
  logic             err_next;
  logic [TMR_W-1:0] gap_reg;
  logic [TMR_W-1:0] gap_next;
  logic             dIn;
  logic             halfEnd;
  logic [CRC_W-1:0] rxFull;

  assign dIn     = dSync_reg[1];
  assign halfEnd = (dc_reg == div_reg - 10'h001);
  assign busy    = (st_reg != M_IDLE);
  assign rxFull  = ~{rxc_reg[CRC_W-2:0], dIn};

  always_comb begin
    st_next  = st_reg;
    clk_next = clk_reg;
    dc_next  = halfEnd ? '0 : dc_reg + 10'h001;
    idx_next = idx_reg;
    len_next = len_reg;
    psh_next = psh_reg;
    pos_next = pos_reg;
    crc_next = crc_reg;
    rxc_next = rxc_reg;
    bad_next = bad_reg;
    err_next = err_reg;
    gap_next = gap_reg;
    evSet    = '0;
    case (st_reg)
      M_IDLE: begin
        dc_next = '0;
        if (startReq) begin
          clk_next = 1'b0;
          len_next = 5'(RES_MIN) + {3'h0, wd[CTRL_RES +: 2]};
          idx_next = '0;
          psh_next = '0;
          crc_next = CRC_INIT;
          bad_next = 1'b0;
          st_next  = M_LOW;
        end
      end
      M_LOW: begin
        if (halfEnd) begin
          clk_next = 1'b1;
          st_next  = M_HIGH;
        end
      end
      M_HIGH: begin
        if (halfEnd) begin
          if (idx_reg == 5'h00) bad_next = bad_reg | dIn;
          else if (idx_reg == 5'h01) bad_next = bad_reg | ~dIn;
          else if (idx_reg == 5'h02) bad_next = bad_reg | dIn;
          else if (idx_reg < len_reg + 5'h03) begin
            psh_next = {psh_reg[POS_W-2:0], dIn};
            crc_next = crc_step(crc_reg, dIn);
          end else if (idx_reg < len_reg + 5'h05) begin
            crc_next = crc_step(crc_reg, dIn);
            if (idx_reg == len_reg + 5'h03) err_next = dIn;
          end else begin
            rxc_next = {rxc_reg[CRC_W-2:0], dIn};
          end
          idx_next = idx_reg + 5'h01;
          if (idx_reg == len_reg + 5'(TRAIL_W - 1)) begin
            pos_next = psh_reg;
            evSet[EV_DONE]  = 1'b1;
            evSet[EV_CRC]   = (rxFull != crc_reg);
            evSet[EV_FRAME] = bad_reg;
            evSet[EV_FAULT] = ~err_reg;
            gap_next = '0;
            st_next  = M_GAP;
          end else begin
            clk_next = 1'b0;
            st_next  = M_LOW;
          end
        end
      end
      M_GAP: begin
        // no new request until the encoder pause is over
        if (gap_reg == TMR_W'(TMO_CYCLES - 1)) st_next = M_IDLE;
        else gap_next = gap_reg + 12'h001;
      end
      default: begin
        st_next  = M_IDLE;
        clk_next = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dSync_reg <= 2'h3;
      st_reg    <= M_IDLE;
      clk_reg   <= 1'b1;
      dc_reg    <= '0;
      idx_reg   <= '0;
      len_reg   <= 5'(RES_MIN);
      psh_reg   <= '0;
      pos_reg   <= '0;
      crc_reg   <= CRC_INIT;
      rxc_reg   <= '0;
      bad_reg   <= 1'b0;
      err_reg   <= 1'b1;
      gap_reg   <= '0;
    end else begin
      dSync_reg <= {dSync_reg[0], link.linkData};
      st_reg    <= st_next;
      clk_reg   <= clk_next;
      dc_reg    <= dc_next;
      idx_reg   <= idx_next;
      len_reg   <= len_next;
      psh_reg   <= psh_next;
      pos_reg   <= pos_next;
      crc_reg   <= crc_next;
      rxc_reg   <= rxc_next;
      bad_reg   <= bad_next;
      err_reg   <= err_next;
      gap_reg   <= gap_next;
    end
  end

  assign link.linkClk = clk_reg;
endmodule : enc_master_end
`default_nettype wire

// ### verification/enc_link_monitor_monitor.sv
/*
  Concurrent checks on the serial link between master and encoder ends.
  Assumes the bench instantiates it beside the interface joining both ends.
*/
`timescale 1ns/1ps
`default_nettype none
module enc_link_monitor (
  input wire logic clk_sys,     // system clock
  input wire logic rstn,        // async reset, low
  input wire logic linkClk,     // master clock on the wire
  input wire logic linkData,    // encoder data on the wire
  input wire logic frameActive, // encoder frame or pause
  input wire logic svcActive    // encoder service mode
);
  import enc_link_pkg::*;
  default clocking mcb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ==========================================================
  // helper counters
  logic        clkPrev_reg, clkPrev_next;
  logic [7:0]  sinceRise_reg, sinceRise_next;
  logic [11:0] lowRun_reg, lowRun_next;
  always_comb begin
    clkPrev_next = linkClk;
    sinceRise_next = (linkClk && !clkPrev_reg) ? 8'h00 :
                     (sinceRise_reg == 8'hFF) ? sinceRise_reg : sinceRise_reg + 8'h01;
    // saturate: a long pause must not wrap back below the bound
    lowRun_next = linkData ? 12'h000 : (lowRun_reg == 12'hFFF) ? lowRun_reg : lowRun_reg + 12'h001;
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      clkPrev_reg   <= 1'b1;
      sinceRise_reg <= 8'hFF;
      lowRun_reg    <= 12'h000;
    end else begin
      clkPrev_reg   <= clkPrev_next;
      sinceRise_reg <= sinceRise_next;
      lowRun_reg    <= lowRun_next;
    end
  end
  // ==========================================================
  // assertions
  sequence ackLow;
    ##[0:3] !linkData;
  endsequence
  sequence newFrame;
    $rose(frameActive) && !svcActive;
  endsequence
  reset_state_a: assert property (!$past(rstn) |-> linkClk && linkData && !frameActive && !svcActive)
    else $error("link not idle after reset");
  clk_low_min_a: assert property ($fell(linkClk) |-> !linkClk [*8])
    else $error("link clock low half too short");
  clk_high_min_a: assert property ($rose(linkClk) |-> linkClk [*8])
    else $error("link clock high half too short");
  ack_low_a: assert property (newFrame |-> ackLow)
    else $error("no acknowledge low at frame start");
  idle_high_a: assert property (!frameActive && !svcActive && !$past(svcActive) |-> linkData)
    else $error("data line not high while idle");
  shift_on_rise_a: assert property ($changed(linkData) && frameActive && !svcActive |-> sinceRise_reg <= 8'h08)
    else $error("data changed away from a clock rise");
  pause_len_a: assert property ($rose(linkData) && !frameActive && !svcActive |-> lowRun_reg >= 12'hC1C)
    else $error("pause shorter than the timeout");
  svc_excl_a: assert property (svcActive |-> !frameActive)
    else $error("service mode during a frame");
  frame_seen_c: cover property (newFrame);
endmodule : enc_link_monitor
`default_nettype wire

// ### verification/tb_top.sv
/*
  Self-checking bench: master and encoder ends joined, plus a lone encoder
  without self-test on a bench-made 160 ns link clock.
  Assumes package and interface are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import enc_link_pkg::*;
  logic        clk_sys, rstn, read, write, waitrequest, irq, bitOk;
  logic        svcReq2, svcTx2, svcRx2, svcActive2, svcActive, frameActive;
  logic [4:0]  address;
  logic [3:0]  be;
  logic [31:0] writedata, readdata, cap, cap2, q;
  logic [19:0] position, pos2;
  res_sel_t    resSel;
  int          error_cnt, n_checks, nCap, cyc;
  logic [19:0] posTab [4] = '{20'hA_5A5C, 20'h3_C3C1, 20'hF_0F0F, 20'h8_0001};
  enc_link_if lnk();
  enc_link_if lnk2();
  enc_master_end enc_master_end_i (.clk_sys(clk_sys), .rstn(rstn), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(be), .readdata(readdata), .waitrequest(waitrequest), .irq(irq), .link(lnk));
  enc_slave_end enc_slave_end_i (.clk_sys(clk_sys), .rstn(rstn), .link(lnk), .position(position), .resSel(resSel),
    .bitOk(bitOk), .svcReq(1'b0), .svcTx(1'b1), .svcRx(), .svcActive(svcActive), .frameActive(frameActive));
  enc_slave_end #(.hasBit(1'b0)) enc_slave_end_i2 (.clk_sys(clk_sys), .rstn(rstn), .link(lnk2), .position(pos2),
    .resSel(2'h0), .bitOk(1'b0), .svcReq(svcReq2), .svcTx(svcTx2), .svcRx(svcRx2), .svcActive(svcActive2),
    .frameActive());
  enc_link_monitor enc_link_monitor_i (.clk_sys(clk_sys), .rstn(rstn), .linkClk(lnk.linkClk),
    .linkData(lnk.linkData), .frameActive(frameActive), .svcActive(svcActive));
  // ==========================================================
  // clock, timeout, wire capture
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      stop_test();
    end
  end
  // one bit per fall: idle level first, the last bit is still on the line at done
  always @(negedge lnk.linkClk) begin
    cap = {cap[30:0], lnk.linkData};
    nCap++;
  end
  // ==========================================================
  // tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] rq);
    int n;
    n = 0;
    @(posedge clk_sys);
    address <= a; write <= wr; read <= !wr; writedata <= d;
    // values read here are those sampled by the edge itself
    do begin
      @(posedge clk_sys);
      n++;
    end while (waitrequest !== 1'b0 && n < 100);
    if (n == 100) chk(32'h0, 32'h1);
    rq = readdata;
    write <= 1'b0; read <= 1'b0;
  endtask : bus
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rd
  task automatic wait_stat(input int b, input logic v);
    int n;
    n = 0;
    do begin
      bus(1'b0, REG_STAT, 32'h0, q);
      n++;
    end while (q[b] !== v && n < 2000);
    if (n == 2000) chk(32'h0, 32'h1);
  endtask : wait_stat
  function automatic logic [31:0] frame_of(input logic [19:0] p, input int res, input logic e);
    logic [31:0] f;
    logic [5:0]  c;
    logic        b;
    // ack low, start high, zero low lead the frame
    f = 32'h0000_0002;
    c = 6'h00;
    for (int i = res + 1; i >= 0; i--) begin
      b = (i >= 2) ? p[i-2] : (i == 1) ? e : 1'b1;
      c = {c[4:0], 1'b0} ^ ((c[5] ^ b) ? 6'h03 : 6'h00);
      f = {f[30:0], b};
    end
    return {f[25:0], ~c};
  endfunction : frame_of
  task automatic run_frame(input int r);
    int t0;
    logic [31:0] fx;
    position <= posTab[r]; resSel <= 2'(r); bitOk <= (r != 2);
    wr(REG_MASK, (r == 3) ? 32'h0 : 32'h0000_0012);
    cap = 32'h0;
    nCap = 0;
    wr(REG_CTRL, 32'(2 * r + 1));
    wait_stat(1, 1'b1);
    t0 = cyc;
    chk(nCap, r + 28);
    fx = frame_of(posTab[r], r + 17, r != 2) | (32'h1 << (r + 28));
    chk({cap[30:0], lnk.linkData}, fx);
    rd(REG_POS, {12'h0, posTab[r]} & ((32'h1 << (r + 17)) - 32'h1));
    rd(REG_STAT, (r == 2) ? 32'h0000_0013 : 32'h0000_0003);
    chk({31'h0, irq}, 32'(r != 3));
    wr(REG_STAT, 32'h0000_001E);
    rd(REG_STAT, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wait_stat(0, 1'b0);
    chk(32'(cyc - t0 >= 3100 && cyc - t0 <= 3160), 32'h1);
  endtask : run_frame
  task automatic lone_frame();
    logic [31:0] f2;
    f2 = frame_of(pos2, 17, 1'b1);
    // one rise beyond the frame falls into the pause and is ignored
    for (int i = 0; i < 29; i++) begin
      @(posedge clk_sys) lnk2.linkClk <= 1'b0;
      repeat (10) @(posedge clk_sys);
      lnk2.linkClk <= 1'b1;
      repeat (9) @(posedge clk_sys);
      cap2 = {cap2[30:0], lnk2.linkData};
    end
    chk(cap2 >> 1, f2);
    chk({31'h0, cap2[0]}, {31'h0, f2[0]});
    repeat (3200) @(posedge clk_sys);
    chk({31'h0, lnk2.linkData}, 32'h1);
    svcReq2 <= 1'b1; svcTx2 <= 1'b0; lnk2.linkClk <= 1'b0;
    repeat (8) @(posedge clk_sys);
    chk({29'h0, svcActive2, lnk2.linkData, svcRx2}, 32'h4);
  endtask : lone_frame
  task automatic stop_test();
    $display("errors %0d checks %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test
  // ==========================================================
  // main sequence
  initial begin
    rstn = 1'b0; read = 1'b0; write = 1'b0; address = 5'h00; writedata = 32'h0; position = 20'h0;
    resSel = 2'h0; bitOk = 1'b1; pos2 = 20'h5_5AA3; svcReq2 = 1'b0; svcTx2 = 1'b1; lnk2.linkClk = 1'b1;
    cap = 32'h0; cap2 = 32'h0; be = 4'hF;
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    chk({29'h0, svcActive, lnk.linkData, lnk.linkClk}, 32'h3);
    rd(REG_DIV, 32'h0000_0032);
    wr(5'h14, 32'hFFFF_FFFF);
    rd(5'h14, 32'h0);
    be <= 4'h1;
    wr(REG_DIV, 32'h0000_0007);
    rd(REG_DIV, 32'h0000_0032);
    be <= 4'hF;
    wr(REG_DIV, 32'h0000_0005);
    rd(REG_DIV, 32'h0000_000D);
    for (int r = 0; r < 4; r++) run_frame(r);
    lone_frame();
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
